// file: nco_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// far side: drives the chosen source clock, counts what comes out
module nco_far_model (
   input wire logic core_clk, // system clock
   input wire logic rst_b, // async reset, active low
   input wire logic [1:0] sel, // source to toggle, 3 toggles all
   input wire logic carry, // raw overflow
   input wire logic out_level, // final output level
   output logic [2:0] src, // clock sources
   output logic [7:0] carry_cnt, // overflows seen
   output logic [7:0] rise_cnt // output rising edges seen
);
   logic out_q;
   initial src = 3'h0;
   // the source stands low between bursts, like a gated clock
   task automatic send(input int n);
      for (int i = 0; i < 2 * n; i++)
      begin
         @(posedge core_clk);
         src <= (i % 2 == 1) ? 3'h0 : ((sel == 2'h3) ? 3'h7 : (3'h1 << sel));
         repeat (3) @(posedge core_clk);
      end
   endtask
   always_ff @(posedge core_clk or negedge rst_b)
      if (!rst_b)
      begin
         out_q <= 1'b0;
         carry_cnt <= 8'h00;
         rise_cnt <= 8'h00;
      end
      else
      begin
         out_q <= out_level;
         carry_cnt <= carry_cnt + {7'h00, carry};
         rise_cnt <= rise_cnt + {7'h00, out_level & ~out_q};
      end
endmodule
`default_nettype wire

// file: nco_map.svh
`ifndef NCO_MAP_SVH
`define NCO_MAP_SVH
`define NCO_ACC_W 20
`define NCO_ACC_RST 20'h00000
`define NCO_INC_RST 20'h00000
`define NCO_PWS_W 3
`define NCO_WCNT_W 8
`define NCO_CKS_FAST 2'h0
`define NCO_CKS_SYS 2'h1
`define NCO_CKS_LC1 2'h2
`define NCO_CKS_RSVD 2'h3
`define NCO_BYTE_LO 2'h0
`define NCO_BYTE_HI 2'h1
`define NCO_BYTE_UP 2'h2
`define NCO_LOAD_EDGES 2'h2
`endif

// file: nco_pkg.sv
package nco_pkg;
   typedef struct packed {
      logic osc_module_on;
      logic output_invert;
      logic pulse_mode_select;
      logic [2:0] pulse_width_select;
      logic [1:0] input_clock_select;
   } nco_cfg_t;
   typedef struct packed {
      logic wr;
      logic rd_unused;
      logic [1:0] sel;
      logic [7:0] data;
   } nco_wr_t;
   typedef enum logic [1:0] {NCO_LD_IDLE, NCO_LD_WAIT1, NCO_LD_WAIT2} nco_ld_state_t;
endpackage

// file: nco_top.sv
`include "nco_map.svh"
`timescale 1ns/1ps
`default_nettype none
module nco_top (
   input wire logic core_clk, // system clock, 100 MHz
   input wire logic rst_b, // async reset, active low
   input wire nco_pkg::nco_cfg_t cfg, // control and clock configuration bits
   input wire logic inc_wr, // one-cycle write strobe to an increment byte
   input wire logic acc_wr, // one-cycle write strobe to an accumulator byte
   input wire logic [1:0] byte_sel, // byte select: low, high, upper
   input wire logic [7:0] wr_data, // write data
   input wire logic irq_flag_clr, // software clears overflow flag, pulse
   input wire logic overflow_irq_enable, // overflow interrupt enable
   input wire logic peripheral_irq_enable, // peripheral interrupt enable
   input wire logic global_irq_enable, // global interrupt enable
   input wire logic internal_fast_oscillator, // fast oscillator clock input
   input wire logic sys_osc_clk, // system oscillator clock input
   input wire logic logic_cell_one_output, // logic cell output
   output logic [19:0] acc_value, // accumulator readback
   output logic [19:0] inc_value, // increment register readback
   output logic osc_output_level, // final output level
   output logic accumulator_carry, // raw overflow, one-cycle pulse per overflowing input edge
   output logic overflow_irq_flag, // sticky overflow flag
   output logic overflow_irq_event, // gated interrupt request
   output logic fast_osc_keep_on // request fast oscillator stays on in sleep
);
   // ==========================================
   // input clock selection and synchroniser
   // ==========================================
   // the selected source is sampled, not used as a clock, so every source
   // must hold each level for at least two core_clk cycles
   // a level counts only once stages two and three agree, which filters
   // a one-cycle glitch at the cost of one extra cycle of latency
   logic [2:0] clk_sync;
   logic clk_lvl;
   wire logic sel_clk_raw;
   wire logic in_rise;
   assign sel_clk_raw = (cfg.input_clock_select == `NCO_CKS_FAST) ? internal_fast_oscillator :
                        (cfg.input_clock_select == `NCO_CKS_SYS) ? sys_osc_clk :
                        (cfg.input_clock_select == `NCO_CKS_LC1) ? logic_cell_one_output :
                        1'b0;
   assign in_rise = clk_sync[1] & clk_sync[2] & ~clk_lvl & cfg.osc_module_on;
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         clk_sync <= 3'h0;
         clk_lvl <= 1'b0;
      end
      else
      begin
         clk_sync <= {clk_sync[1:0], sel_clk_raw};
         if (clk_sync[1] == clk_sync[2])
            clk_lvl <= clk_sync[2];
      end
   end

   // ==========================================
   // increment registers and hidden buffer
   // ==========================================
   logic [19:0] inc_buf;
   nco_pkg::nco_ld_state_t ld_state;
   nco_pkg::nco_ld_state_t next_ld_state;
   wire logic low_wr;
   wire logic buf_load;
   wire logic [19:0] next_inc;
   assign low_wr = inc_wr && byte_sel == `NCO_BYTE_LO;
   assign next_inc = !inc_wr ? inc_value :
                     (byte_sel == `NCO_BYTE_LO) ? {inc_value[19:8], wr_data} :
                     (byte_sel == `NCO_BYTE_HI) ? {inc_value[19:16], wr_data, inc_value[7:0]} :
                     (byte_sel == `NCO_BYTE_UP) ? {wr_data[3:0], inc_value[15:0]} :
                     inc_value;
   // load on the second input edge after the low-byte write
   assign buf_load = (ld_state == nco_pkg::NCO_LD_WAIT2) && in_rise;
   always_comb
   begin
      next_ld_state = ld_state;
      case (ld_state)
         nco_pkg::NCO_LD_IDLE:
            if (low_wr && cfg.osc_module_on)
               next_ld_state = nco_pkg::NCO_LD_WAIT1;
         nco_pkg::NCO_LD_WAIT1:
            if (in_rise)
               next_ld_state = nco_pkg::NCO_LD_WAIT2;
         nco_pkg::NCO_LD_WAIT2:
            if (in_rise)
               next_ld_state = nco_pkg::NCO_LD_IDLE;
         default:
            next_ld_state = nco_pkg::NCO_LD_IDLE;
      endcase
      if (!cfg.osc_module_on)
         next_ld_state = nco_pkg::NCO_LD_IDLE;
   end
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         inc_value <= `NCO_INC_RST;
         inc_buf <= `NCO_INC_RST;
         ld_state <= nco_pkg::NCO_LD_IDLE;
      end
      else
      begin
         inc_value <= next_inc;
         ld_state <= next_ld_state;
         if (!cfg.osc_module_on)
            inc_buf <= next_inc;
         else if (buf_load)
            inc_buf <= inc_value;
      end
   end

   // ==========================================
   // accumulator
   // ==========================================
   wire logic [20:0] sum;
   wire logic [19:0] next_acc;
   assign sum = {1'b0, acc_value} + {1'b0, inc_buf};
   assign next_acc = (acc_wr && byte_sel == `NCO_BYTE_LO) ? {acc_value[19:8], wr_data} :
                     (acc_wr && byte_sel == `NCO_BYTE_HI) ?
                        {acc_value[19:16], wr_data, acc_value[7:0]} :
                     (acc_wr && byte_sel == `NCO_BYTE_UP) ? {wr_data[3:0], acc_value[15:0]} :
                     in_rise ? sum[19:0] : acc_value;
   // only a write that really lands on a byte suppresses the overflow
   wire logic acc_hit;
   assign acc_hit = acc_wr && (byte_sel == `NCO_BYTE_LO || byte_sel == `NCO_BYTE_HI ||
                               byte_sel == `NCO_BYTE_UP);
   wire logic ovf;
   assign ovf = in_rise & sum[20] & ~acc_hit;
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         acc_value <= `NCO_ACC_RST;
         accumulator_carry <= 1'b0;
      end
      else
      begin
         acc_value <= next_acc;
         accumulator_carry <= ovf;
      end
   end

   // ==========================================
   // output shaping: toggle or pulse
   // ==========================================
   logic fdc_q;
   logic pf_q;
   logic [`NCO_WCNT_W-1:0] width_cnt;
   wire logic [`NCO_WCNT_W-1:0] width_periods;
   wire logic core_out;
   wire logic final_out;
   assign width_periods = 8'h01 << cfg.pulse_width_select;
   assign core_out = cfg.pulse_mode_select ? pf_q : fdc_q;
   assign final_out = cfg.osc_module_on & core_out ^ cfg.output_invert;
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fdc_q <= 1'b0;
         pf_q <= 1'b0;
         width_cnt <= 8'h00;
      end
      else if (!cfg.osc_module_on)
      begin
         fdc_q <= 1'b0;
         pf_q <= 1'b0;
         width_cnt <= 8'h00;
      end
      else
      begin
         if (ovf)
            fdc_q <= ~fdc_q;
         // an overflow during the pulse restarts the width, so an over-long
         // width holds the output active with no toggling
         if (ovf)
         begin
            pf_q <= 1'b1;
            width_cnt <= width_periods;
         end
         else if (in_rise && pf_q)
         begin
            if (width_cnt == 8'h01)
               pf_q <= 1'b0;
            width_cnt <= width_cnt - 8'h01;
         end
      end
   end

   // ==========================================
   // status, interrupt and sleep hint
   // ==========================================
   logic out_prev;
   logic pol_prev;
   wire logic irq_en_all;
   wire logic pol_changed;
   wire logic pol_irq;
   assign irq_en_all = cfg.osc_module_on & overflow_irq_enable &
                       peripheral_irq_enable & global_irq_enable;
   assign pol_changed = pol_prev != cfg.output_invert;
   // a polarity change flips the pin, which is flagged as an event only while irq_en_all is set
   assign pol_irq = irq_en_all & pol_changed & (final_out != out_prev);
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         osc_output_level <= 1'b0;
         out_prev <= 1'b0;
         pol_prev <= 1'b0;
         overflow_irq_flag <= 1'b0;
         overflow_irq_event <= 1'b0;
         fast_osc_keep_on <= 1'b0;
      end
      else
      begin
         osc_output_level <= final_out;
         out_prev <= final_out;
         pol_prev <= cfg.output_invert;
         // set wins over the software clear
         if (ovf || pol_irq)
            overflow_irq_flag <= 1'b1;
         else if (irq_flag_clr)
            overflow_irq_flag <= 1'b0;
         overflow_irq_event <= irq_en_all & (overflow_irq_flag | ovf | pol_irq);
         fast_osc_keep_on <= cfg.osc_module_on &&
                             cfg.input_clock_select == `NCO_CKS_FAST;
      end
   end

   // ==========================================
   // checks
   // ==========================================
   chk_flag_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
      overflow_irq_flag && !irq_flag_clr |=> overflow_irq_flag)
      else $error("overflow flag dropped without clear");
   chk_ovf_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
      ovf |=> overflow_irq_flag)
      else $error("overflow did not set flag");
   chk_off_holds_acc: assert property (@(posedge core_clk) disable iff (!rst_b)
      !cfg.osc_module_on && !acc_wr |=> $stable(acc_value))
      else $error("accumulator moved while disabled");
   chk_fdc_toggle: assert property (@(posedge core_clk) disable iff (!rst_b)
      ovf && cfg.osc_module_on |=> fdc_q != $past(fdc_q))
      else $error("toggle missed on overflow");
   chk_pf_start: assert property (@(posedge core_clk) disable iff (!rst_b)
      ovf && cfg.osc_module_on |=> pf_q && width_cnt == $past(width_periods))
      else $error("pulse did not start");
   chk_off_buf_load: assert property (@(posedge core_clk) disable iff (!rst_b)
      !cfg.osc_module_on |=> inc_buf == inc_value)
      else $error("buffer not loaded while disabled");
   chk_out_level: assert property (@(posedge core_clk) disable iff (!rst_b)
      1'b1 |=> osc_output_level == $past(final_out))
      else $error("status level mismatch");
   chk_keep_on: assert property (@(posedge core_clk) disable iff (!rst_b)
      cfg.osc_module_on && cfg.input_clock_select == `NCO_CKS_FAST |=> fast_osc_keep_on)
      else $error("fast oscillator hint missing");
   chk_keep_off: assert property (@(posedge core_clk) disable iff (!rst_b)
      !cfg.osc_module_on |=> !fast_osc_keep_on)
      else $error("fast oscillator hint while disabled");
   chk_carry_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
      accumulator_carry |=> !accumulator_carry)
      else $error("carry longer than one cycle");
   chk_carry_from_ovf: assert property (@(posedge core_clk) disable iff (!rst_b)
      ovf |=> accumulator_carry)
      else $error("carry missing after overflow");
   chk_no_carry_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
      !ovf |=> !accumulator_carry)
      else $error("carry without overflow");
   chk_add_step: assert property (@(posedge core_clk) disable iff (!rst_b)
      in_rise && !acc_hit |=> acc_value == $past(sum[19:0]))
      else $error("accumulator add wrong");
   chk_idle_acc_holds: assert property (@(posedge core_clk) disable iff (!rst_b)
      !in_rise && !acc_hit |=> $stable(acc_value))
      else $error("accumulator moved without input edge");
   chk_acc_wr_low: assert property (@(posedge core_clk) disable iff (!rst_b)
      acc_hit && byte_sel == `NCO_BYTE_LO |=> acc_value[7:0] == $past(wr_data))
      else $error("accumulator low byte write lost");
   chk_inc_wr_low: assert property (@(posedge core_clk) disable iff (!rst_b)
      inc_wr && byte_sel == `NCO_BYTE_LO |=> inc_value[7:0] == $past(wr_data))
      else $error("increment low byte write lost");
   chk_inc_wr_up: assert property (@(posedge core_clk) disable iff (!rst_b)
      inc_wr && byte_sel == `NCO_BYTE_UP |=> inc_value[19:16] == $past(wr_data[3:0]))
      else $error("increment upper byte write lost");
   chk_buf_hidden: assert property (@(posedge core_clk) disable iff (!rst_b)
      cfg.osc_module_on && !buf_load |=> $stable(inc_buf))
      else $error("buffer changed without load");
   chk_buf_load_on: assert property (@(posedge core_clk) disable iff (!rst_b)
      buf_load && cfg.osc_module_on |=> inc_buf == $past(inc_value))
      else $error("buffer load wrong");
   chk_ld_arm: assert property (@(posedge core_clk) disable iff (!rst_b)
      low_wr && cfg.osc_module_on && ld_state == nco_pkg::NCO_LD_IDLE |=>
      ld_state == nco_pkg::NCO_LD_WAIT1)
      else $error("low byte write did not arm load");
   chk_off_level: assert property (@(posedge core_clk) disable iff (!rst_b)
      !cfg.osc_module_on |-> final_out == cfg.output_invert)
      else $error("output not inactive while disabled");
   chk_pf_end: assert property (@(posedge core_clk) disable iff (!rst_b)
      in_rise && pf_q && !ovf && width_cnt == 8'h01 |=> !pf_q)
      else $error("pulse did not end");
   chk_pf_count: assert property (@(posedge core_clk) disable iff (!rst_b)
      in_rise && pf_q && !ovf && width_cnt > 8'h01 |=>
      pf_q && width_cnt == $past(width_cnt) - 8'h01)
      else $error("pulse width count wrong");
   chk_width_min: assert property (@(posedge core_clk) disable iff (!rst_b)
      cfg.pulse_width_select == 3'h0 |-> width_periods == 8'h01)
      else $error("shortest width wrong");
   chk_width_max: assert property (@(posedge core_clk) disable iff (!rst_b)
      cfg.pulse_width_select == 3'h7 |-> width_periods == 8'h80)
      else $error("longest width wrong");
   chk_flag_clr: assert property (@(posedge core_clk) disable iff (!rst_b)
      irq_flag_clr && !ovf && !pol_irq |=> !overflow_irq_flag)
      else $error("flag clear ignored");
   chk_irq_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
      !irq_en_all |=> !overflow_irq_event)
      else $error("interrupt raised while gated");
   chk_irq_raise: assert property (@(posedge core_clk) disable iff (!rst_b)
      irq_en_all && overflow_irq_flag |=> overflow_irq_event)
      else $error("interrupt missing");
   chk_pol_irq: assert property (@(posedge core_clk) disable iff (!rst_b)
      irq_en_all && pol_changed && final_out != out_prev |=> overflow_irq_flag)
      else $error("polarity change not flagged");
   chk_rsvd_src: assert property (@(posedge core_clk) disable iff (!rst_b)
      cfg.input_clock_select == `NCO_CKS_RSVD |-> !sel_clk_raw)
      else $error("reserved source not silent");
   chk_mode_sel: assert property (@(posedge core_clk) disable iff (!rst_b)
      !cfg.pulse_mode_select |-> core_out == fdc_q)
      else $error("toggle mode not selected");
endmodule
`default_nettype wire

// file: tb_nco_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_nco_top;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   nco_pkg::nco_cfg_t cfg;
   logic inc_wr;
   logic acc_wr;
   logic [1:0] byte_sel;
   logic [7:0] wr_data;
   logic irq_flag_clr;
   logic ov_en;
   logic pe_en;
   logic gl_en;
   logic [2:0] src;
   logic [19:0] acc_value, inc_value;
   logic out_lvl, carry, flag, irq, keep_on;
   logic [7:0] carry_cnt, rise_cnt, r0;
   int error_cnt = 0;
   int checked = 0;
   int cycles = 0;
   nco_top u_nco_top (.core_clk(core_clk), .rst_b(rst_b), .cfg(cfg), .inc_wr(inc_wr),
      .acc_wr(acc_wr), .byte_sel(byte_sel), .wr_data(wr_data), .irq_flag_clr(irq_flag_clr),
      .overflow_irq_enable(ov_en), .peripheral_irq_enable(pe_en),
      .global_irq_enable(gl_en), .internal_fast_oscillator(src[0]), .sys_osc_clk(src[1]),
      .logic_cell_one_output(src[2]), .acc_value(acc_value), .inc_value(inc_value),
      .osc_output_level(out_lvl), .accumulator_carry(carry), .overflow_irq_flag(flag),
      .overflow_irq_event(irq), .fast_osc_keep_on(keep_on));
   nco_far_model u_nco_far_model (.core_clk(core_clk), .rst_b(rst_b),
      .sel(cfg.input_clock_select), .carry(carry), .out_level(out_lvl), .src(src),
      .carry_cnt(carry_cnt), .rise_cnt(rise_cnt));
   // ==========================================================
   // clock, timeout, shared tasks
   initial
   begin
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         error_cnt++;
         final_report();
      end
   end
   task automatic chk(input string name, input logic [19:0] seen, input logic [19:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic is_acc, input logic [1:0] sel, input logic [7:0] d);
      @(posedge core_clk);
      inc_wr <= !is_acc;
      acc_wr <= is_acc;
      byte_sel <= sel;
      wr_data <= d;
      @(posedge core_clk);
      inc_wr <= 1'b0;
      acc_wr <= 1'b0;
   endtask
   task automatic settle();
      repeat (4) @(posedge core_clk);
      #1;
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_disabled();
      chk("acc rst", acc_value, 20'h00000);
      chk("inc rst", inc_value, 20'h00000);
      chk("flag rst", {19'h0, flag}, 20'h0);
      wr(1'b0, 2'h2, 8'h04);
      wr(1'b0, 2'h1, 8'h00);
      wr(1'b0, 2'h3, 8'hff);
      wr(1'b0, 2'h0, 8'h00);
      wr(1'b1, 2'h0, 8'h10);
      settle();
      chk("inc bytes", inc_value, 20'h40000);
      chk("acc write", acc_value, 20'h00010);
      u_nco_far_model.send(3);
      settle();
      chk("acc held off", acc_value, 20'h00010);
      chk("out off", {19'h0, out_lvl}, 20'h0);
      $display("done: disabled");
   endtask
   task automatic t_fdc();
      ov_en <= 1'b1;
      pe_en <= 1'b1;
      gl_en <= 1'b1;
      cfg.osc_module_on <= 1'b1;
      u_nco_far_model.send(4);
      settle();
      chk("acc add", acc_value, 20'h00010);
      chk("carries", {12'h0, carry_cnt}, 20'h1);
      chk("toggle 1", {19'h0, out_lvl}, 20'h1);
      chk("irq", {18'h0, flag, irq}, 20'h3);
      chk("keep fast on", {19'h0, keep_on}, 20'h1);
      gl_en <= 1'b0;
      u_nco_far_model.send(4);
      settle();
      chk("toggle 2", {19'h0, out_lvl}, 20'h0);
      chk("irq gated", {18'h0, flag, irq}, 20'h2);
      wr(1'b0, 2'h2, 8'h08);
      wr(1'b0, 2'h1, 8'h00);
      wr(1'b0, 2'h0, 8'h00);
      u_nco_far_model.send(4);
      settle();
      chk("late load", acc_value, 20'h80010);
      chk("carries 3", {12'h0, carry_cnt}, 20'h3);
      $display("done: fixed duty");
   endtask
   task automatic t_pulse();
      cfg.pulse_mode_select <= 1'b1;
      settle();
      r0 = rise_cnt;
      u_nco_far_model.send(4);
      settle();
      chk("pulses", 20'(rise_cnt - r0), 20'h2);
      chk("pulse end", {19'h0, out_lvl}, 20'h0);
      cfg.pulse_width_select <= 3'h7;
      r0 = rise_cnt;
      u_nco_far_model.send(8);
      settle();
      chk("no toggle", 20'(rise_cnt - r0), 20'h1);
      chk("held high", {19'h0, out_lvl}, 20'h1);
      irq_flag_clr <= 1'b1;
      @(posedge core_clk);
      irq_flag_clr <= 1'b0;
      #1;
      chk("flag clr", {19'h0, flag}, 20'h0);
      gl_en <= 1'b1;
      cfg.output_invert <= 1'b1;
      settle();
      chk("inverted", {19'h0, out_lvl}, 20'h0);
      chk("pol irq", {19'h0, flag}, 20'h1);
      $display("done: pulse");
   endtask
   task automatic t_sources();
      cfg.input_clock_select <= 2'h2;
      u_nco_far_model.send(1);
      settle();
      chk("logic cell", acc_value, 20'h00010);
      cfg.input_clock_select <= 2'h1;
      u_nco_far_model.send(1);
      settle();
      chk("sys clock", acc_value, 20'h80010);
      chk("no keep", {19'h0, keep_on}, 20'h0);
      cfg.input_clock_select <= 2'h3;
      u_nco_far_model.send(2);
      settle();
      chk("reserved", acc_value, 20'h80010);
      cfg.osc_module_on <= 1'b0;
      settle();
      chk("off level", {19'h0, out_lvl}, 20'h1);
      $display("done: sources");
   endtask
   initial
   begin
      cfg <= '0;
      inc_wr <= 1'b0;
      acc_wr <= 1'b0;
      byte_sel <= 2'h0;
      wr_data <= 8'h00;
      irq_flag_clr <= 1'b0;
      ov_en <= 1'b0;
      pe_en <= 1'b0;
      gl_en <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      settle();
      t_disabled();
      t_fdc();
      t_pulse();
      t_sources();
      final_report();
   end
endmodule
`default_nettype wire
